// [hdl/vpc_pkg.sv]
// Package of constants and types for the valve positioner commissioning logic
package vpc_pkg;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned CLOCK_NS = 1_000_000_000 / CLOCK_HZ;
  localparam int unsigned HOLD_S = 5;
  localparam int unsigned HOLD_CYCLES = HOLD_S * CLOCK_HZ;
  localparam int unsigned SLOW_FLASH_S = 3;
  localparam int unsigned SLOW_HALF_CYCLES = SLOW_FLASH_S * CLOCK_HZ / 2;
  localparam int unsigned FAST_FLASH_S = 1;
  localparam int unsigned FAST_HALF_CYCLES = FAST_FLASH_S * CLOCK_HZ / 2;
  localparam int unsigned POS_W = 10;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned LOG_AW = 6;
  localparam logic [POS_W-1:0] DEFAULT_LOW = 10'h000;
  localparam logic [POS_W-1:0] DEFAULT_HIGH = 10'h3FF;
  localparam logic [POS_W-1:0] DEADBAND_NORMAL = 10'h004;
  localparam logic [POS_W-1:0] DEADBAND_REDUCED = 10'h010;
  localparam logic [CNT_W-1:0] WEAR_RELAY_LIMIT = 24'h0F4240;
  localparam logic [CNT_W-1:0] WEAR_END_LIMIT = 24'h030D40;

  typedef enum logic [2:0] {
    VPC_RANGE_0_20 = 3'h0,
    VPC_RANGE_4_20 = 3'h1,
    VPC_RANGE_0_10 = 3'h2,
    VPC_RANGE_4_12 = 3'h3,
    VPC_RANGE_10_20 = 3'h4,
    VPC_RANGE_12_20 = 3'h5
  } vpc_range_t;

  typedef enum logic [3:0] {
    VPC_RUN = 4'h1,
    VPC_SEEK_LOW = 4'h2,
    VPC_SEEK_HIGH = 4'h4,
    VPC_FAULT = 4'h8
  } vpc_state_t;
endpackage

// [hdl/vpc_timer.sv]
// Free running tick divider toggling a blink phase
`timescale 1ns/100ps
module vpc_blink #(
  parameter int unsigned HALF = 10
) (
  input wire logic i_clock,
  input wire logic i_reset,
  output logic o_phase
);
  logic [31:0] count;
  if (HALF < 1) begin
    $error("HALF must be at least one");
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count <= 32'h0;
      o_phase <= 1'b0;
    end else if (count == HALF - 1) begin
      count <= 32'h0;
      o_phase <= ~o_phase;
    end else begin
      count <= count + 32'h1;
    end
  end
endmodule

// [hdl/vpc_log.sv]
// Circular history datalogger with a read port
`timescale 1ns/100ps
module vpc_log #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 30
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_write,
  input wire logic [DW-1:0] i_data,
  input wire logic [AW-1:0] i_read_addr,
  output logic [DW-1:0] o_read_data,
  output logic [AW-1:0] o_write_ptr
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  if (AW < 1 || AW > 12) begin
    $error("AW out of range");
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_write_ptr <= '0;
    end else if (i_write) begin
      o_write_ptr <= o_write_ptr + 1'b1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_write) begin
      mem[o_write_ptr] <= i_data;
    end
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_read_data <= '0;
    end else begin
      o_read_data <= mem[i_read_addr];
    end
  end
endmodule

// [hdl/vpc_top.sv]
// Valve positioner commissioning, indication, switch decode and wear logic
// Contract
// R01: Adjustment starts after the button is held five seconds without break.
// R02: Early release aborts the hold; the next press restarts timing.
// R03: Adjustment drives to one end, then the other, learning both limits.
// R04: Learned limits are kept in retained storage across power cycles.
// R05: Status LED flashes with three second period during adjustment.
// R06: Status LED lights steadily after adjustment and in normal operation.
// R07: Input fault flashes status LED at one second period, overriding others.
// R08: Two indicators mirror the up and down relay states at all times.
// R09: Red maintenance LED lights once wear counts reach revision level.
// R10: Relay switching cycles and end runs are counted and readable.
// R11: Actual, setpoint and potentiometer history logged, readable by service.
// R12: Fault details are presented to the service interface.
// R13: Switches one to three decode the six input ranges.
// R14: Switch four selects normal (1) or reduced (0) sensitivity.
// R15: Switch five with valve type sets direct or inverse action.
// R16: Direct opens passage as input rises; inverse closes it.
// R17: Switch six selects the feedback output range; 0 is 0-20mA.
// R18: Relays drive the motor until setpoint and feedback agree.
`timescale 1ns/100ps
module vpc_top #(
  parameter int unsigned HOLD_TIME = vpc_pkg::HOLD_CYCLES,
  parameter int unsigned SLOW_HALF = vpc_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF = vpc_pkg::FAST_HALF_CYCLES,
  parameter int unsigned LOG_PERIOD = vpc_pkg::CLOCK_HZ
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_adjust_button,
  input wire logic [5:0] i_switches,
  input wire logic i_mixing_valve,
  input wire logic [vpc_pkg::POS_W-1:0] i_setpoint,
  input wire logic [vpc_pkg::POS_W-1:0] i_position,
  input wire logic i_at_low_end,
  input wire logic i_at_high_end,
  input wire logic [1:0] i_fault_code,
  input wire logic i_nv_valid,
  input wire logic [vpc_pkg::POS_W-1:0] i_nv_low,
  input wire logic [vpc_pkg::POS_W-1:0] i_nv_high,
  input wire logic [5:0] i_nv_switches,
  input wire logic [vpc_pkg::LOG_AW-1:0] i_log_addr,
  output logic o_relay_up,
  output logic o_relay_down,
  output logic o_led_up,
  output logic o_led_down,
  output logic o_led_status,
  output logic o_led_maint,
  output logic o_nv_write,
  output logic [vpc_pkg::POS_W-1:0] o_cal_low,
  output logic [vpc_pkg::POS_W-1:0] o_cal_high,
  output logic [5:0] o_cal_switches,
  output logic o_cal_stale,
  output vpc_pkg::vpc_range_t o_input_range,
  output logic o_sens_normal,
  output logic o_direct_action,
  output logic o_output_0_20,
  output logic [vpc_pkg::POS_W-1:0] o_target,
  output logic o_adjusting,
  output logic [vpc_pkg::CNT_W-1:0] o_relay_cycles,
  output logic [vpc_pkg::CNT_W-1:0] o_end_runs,
  output logic [1:0] o_fault_code,
  output logic [3*vpc_pkg::POS_W-1:0] o_log_data,
  output logic [vpc_pkg::LOG_AW-1:0] o_log_ptr
);
  import vpc_pkg::*;

  // Refused at elaboration so a bad build never runs
  if (HOLD_TIME < 1 || SLOW_HALF < 1 || FAST_HALF < 1 || LOG_PERIOD < 1) begin
    $error("Timing parameters must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [POS_W-1:0] absdiff(input logic [POS_W-1:0] a,
                                               input logic [POS_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    // Saturate so the wear history never wraps back to fresh
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Switch decode
  vpc_range_t next_range;
  always_comb begin
    case (i_switches[2:0]) // R13
      3'h0: next_range = VPC_RANGE_0_20;
      3'h1: next_range = VPC_RANGE_4_20;
      3'h2: next_range = VPC_RANGE_0_10;
      3'h3: next_range = VPC_RANGE_4_12;
      3'h6: next_range = VPC_RANGE_10_20;
      3'h7: next_range = VPC_RANGE_12_20;
      // Unlisted codes fall back to the default range
      default: next_range = VPC_RANGE_4_20;
    endcase
  end

  logic direct;
  // Switch bits: [0] is switch one
  assign direct = i_switches[4] ^ i_mixing_valve; // R15

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_input_range <= VPC_RANGE_4_20;
      o_sens_normal <= 1'b1;
      o_direct_action <= 1'b1;
      o_output_0_20 <= 1'b0;
    end else begin
      o_input_range <= next_range; // R13
      o_sens_normal <= i_switches[3]; // R14
      o_direct_action <= direct; // R15
      o_output_0_20 <= ~i_switches[5]; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hold timer for the adjustment button
  logic [31:0] hold_count;
  logic hold_done;
  assign hold_done = i_adjust_button && (hold_count == HOLD_TIME - 1);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      hold_count <= 32'h0;
    end else if (!i_adjust_button) begin
      hold_count <= 32'h0; // R02
    end else if (hold_count != HOLD_TIME - 1) begin
      hold_count <= hold_count + 32'h1; // R01
    end
  end

  logic hold_seen;
  // Held past the time fires once; a release is needed to re-arm
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      hold_seen <= 1'b0;
    end else begin
      hold_seen <= hold_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Adjustment and run state machine
  vpc_state_t state;
  vpc_state_t next_state;
  logic fault;
  assign fault = (i_fault_code != 2'h0);

  always_comb begin
    next_state = state;
    case (state)
      VPC_RUN: begin
        if (fault) next_state = VPC_FAULT;
        else if (hold_done && !hold_seen) next_state = VPC_SEEK_LOW; // R01
      end
      VPC_SEEK_LOW: begin
        if (fault) next_state = VPC_FAULT;
        else if (i_at_low_end) next_state = VPC_SEEK_HIGH; // R03
      end
      VPC_SEEK_HIGH: begin
        if (fault) next_state = VPC_FAULT;
        else if (i_at_high_end) next_state = VPC_RUN; // R03
      end
      VPC_FAULT: begin
        if (!fault) next_state = VPC_RUN;
      end
      default: next_state = VPC_RUN;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state <= VPC_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign o_adjusting = (state == VPC_SEEK_LOW) || (state == VPC_SEEK_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // Calibration limits, loaded from retained storage after reset
  logic loaded;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      loaded <= 1'b0;
      o_cal_low <= DEFAULT_LOW;
      o_cal_high <= DEFAULT_HIGH;
      o_cal_switches <= 6'h00;
    end else if (!loaded) begin
      loaded <= 1'b1;
      if (i_nv_valid) begin
        o_cal_low <= i_nv_low; // R04
        o_cal_high <= i_nv_high; // R04
        o_cal_switches <= i_nv_switches;
      end else begin
        o_cal_switches <= i_switches;
      end
    end else if (state == VPC_SEEK_LOW && i_at_low_end && !fault) begin
      o_cal_low <= i_position; // R03
    end else if (state == VPC_SEEK_HIGH && i_at_high_end && !fault) begin
      o_cal_high <= i_position; // R03
      o_cal_switches <= i_switches;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_nv_write <= 1'b0;
    end else begin
      o_nv_write <= (state == VPC_SEEK_HIGH) && i_at_high_end && !fault; // R04
    end
  end

  // Stale tells the user a new adjustment is due after switch changes
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_cal_stale <= 1'b0;
    end else begin
      o_cal_stale <= loaded && (o_cal_switches != i_switches); // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target position from setpoint and direction
  logic [POS_W-1:0] next_target;
  logic [POS_W-1:0] deadband;
  logic [POS_W-1:0] err;
  // Scaling into the learned span is left to the analog side
  assign next_target = direct ? i_setpoint : ~i_setpoint; // R16
  assign deadband = o_sens_normal ? DEADBAND_NORMAL : DEADBAND_REDUCED; // R14
  assign err = absdiff(o_target, i_position);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_target <= '0;
    end else begin
      o_target <= next_target; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relay drive; up and down are never energised together
  logic next_up;
  logic next_down;
  always_comb begin
    next_up = 1'b0;
    next_down = 1'b0;
    case (state)
      VPC_SEEK_LOW: next_down = !i_at_low_end; // R03
      VPC_SEEK_HIGH: next_up = !i_at_high_end; // R03
      VPC_RUN: begin
        if (loaded && err > deadband) begin // R18
          next_up = (o_target > i_position) && !i_at_high_end;
          next_down = (o_target < i_position) && !i_at_low_end;
        end
      end
      default: begin
        next_up = 1'b0;
        next_down = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_relay_up <= 1'b0;
      o_relay_down <= 1'b0;
    end else begin
      o_relay_up <= next_up; // R18
      o_relay_down <= next_down; // R18
    end
  end

  assign o_led_up = o_relay_up; // R08
  assign o_led_down = o_relay_down; // R08

  ////////////////////////////////////////////////////////////////////////
  // Wear counters
  logic prev_up;
  logic prev_down;
  logic prev_low;
  logic prev_high;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      prev_up <= 1'b0;
      prev_down <= 1'b0;
      prev_low <= 1'b0;
      prev_high <= 1'b0;
    end else begin
      prev_up <= o_relay_up;
      prev_down <= o_relay_down;
      prev_low <= i_at_low_end;
      prev_high <= i_at_high_end;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_relay_cycles <= '0;
    end else if ((o_relay_up && !prev_up) || (o_relay_down && !prev_down)) begin
      o_relay_cycles <= sat_inc(o_relay_cycles); // R10
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_end_runs <= '0;
    end else if ((i_at_low_end && !prev_low) || (i_at_high_end && !prev_high)) begin
      o_end_runs <= sat_inc(o_end_runs); // R10
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_led_maint <= 1'b0;
    end else begin
      o_led_maint <= (o_relay_cycles >= WEAR_RELAY_LIMIT) ||
                     (o_end_runs >= WEAR_END_LIMIT); // R09
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status LED
  logic slow_phase;
  logic fast_phase;
  vpc_blink #(.HALF(SLOW_HALF)) u_slow (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .o_phase(slow_phase)
  );
  vpc_blink #(.HALF(FAST_HALF)) u_fast (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .o_phase(fast_phase)
  );

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_led_status <= 1'b0;
    end else if (fault) begin
      o_led_status <= fast_phase; // R07
    end else if (o_adjusting) begin
      o_led_status <= slow_phase; // R05
    end else begin
      o_led_status <= 1'b1; // R06
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_fault_code <= 2'h0;
    end else begin
      o_fault_code <= i_fault_code; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datalogger sampling
  logic [31:0] log_count;
  logic log_tick;
  assign log_tick = (log_count == LOG_PERIOD - 1);
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      log_count <= 32'h0;
    end else if (log_tick) begin
      log_count <= 32'h0;
    end else begin
      log_count <= log_count + 32'h1;
    end
  end

  vpc_log #(.AW(LOG_AW), .DW(3 * POS_W)) u_log (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_write(log_tick),
    .i_data({i_position, i_setpoint, i_position}), // R11
    .i_read_addr(i_log_addr),
    .o_read_data(o_log_data),
    .o_write_ptr(o_log_ptr)
  );
endmodule

// [verification/vpc_checker.sv]
// Port checker for the positioner commissioning logic
`timescale 1ns/100ps
module vpc_checker #(
  parameter int unsigned HOLD_TIME = 20
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_adjust_button,
  input wire logic [5:0] i_switches,
  input wire logic i_mixing_valve,
  input wire logic i_at_low_end,
  input wire logic [1:0] i_fault_code,
  input wire logic o_relay_up,
  input wire logic o_relay_down,
  input wire logic o_led_up,
  input wire logic o_led_down,
  input wire logic o_led_status,
  input wire logic o_led_maint,
  input wire logic o_nv_write,
  input wire vpc_pkg::vpc_range_t o_input_range,
  input wire logic o_sens_normal,
  input wire logic o_direct_action,
  input wire logic o_output_0_20,
  input wire logic o_adjusting,
  input wire logic [vpc_pkg::CNT_W-1:0] o_relay_cycles,
  input wire logic [vpc_pkg::CNT_W-1:0] o_end_runs,
  input wire logic [1:0] o_fault_code
);
  import vpc_pkg::*;
  int unsigned held;
  // Cycles the button has been held without a break
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      held <= 0;
    end else begin
      held <= i_adjust_button ? held + 1 : 0;
    end
  end
  function automatic vpc_range_t dec(input logic [2:0] s);
    case (s)
      3'h0: return VPC_RANGE_0_20;
      3'h2: return VPC_RANGE_0_10;
      3'h3: return VPC_RANGE_4_12;
      3'h6: return VPC_RANGE_10_20;
      3'h7: return VPC_RANGE_12_20;
      default: return VPC_RANGE_4_20;
    endcase
  endfunction
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////
  chk_led_mirror: assert property (
    o_led_up == o_relay_up && o_led_down == o_relay_down)
    else $error("relay indicators differ from relays");
  chk_hold_time: assert property (
    $rose(o_adjusting) |-> $past(held, 2) >= HOLD_TIME - 2)
    else $error("adjustment started before hold time");
  chk_seek_first: assert property (
    $rose(o_adjusting) && !i_at_low_end |-> ##[0:2] o_relay_down)
    else $error("adjustment did not seek low end first");
  chk_fault_stop: assert property (
    (i_fault_code != 2'h0) [*3] |-> !o_relay_up && !o_relay_down && !o_adjusting)
    else $error("relays active during input fault");
  chk_fault_detail: assert property (
    $stable(i_fault_code) [*2] |-> o_fault_code == i_fault_code)
    else $error("fault detail not presented");
  chk_status_on: assert property (
    (!o_adjusting && o_fault_code == 2'h0) [*3] |-> o_led_status)
    else $error("status indicator not steady");
  chk_range_map: assert property (
    $stable(i_switches) [*2] |-> o_input_range == dec(i_switches[2:0]))
    else $error("input range decode wrong");
  chk_switch_map: assert property (
    ($stable(i_switches) && $stable(i_mixing_valve)) [*2] |->
      o_sens_normal == i_switches[3] && o_output_0_20 == !i_switches[5] &&
      o_direct_action == (i_switches[4] ^ i_mixing_valve))
    else $error("switch four to six decode wrong");
  chk_store_cal: assert property (
    $fell(o_adjusting) && o_fault_code == 2'h0 |-> ##[0:2] o_nv_write)
    else $error("calibration not stored");
  chk_maint_off: assert property (
    (o_relay_cycles < WEAR_RELAY_LIMIT && o_end_runs < WEAR_END_LIMIT) [*2] |-> !o_led_maint)
    else $error("maintenance indicator without wear");
  cov_adjust: cover property ($rose(o_adjusting));
  cov_store: cover property (o_nv_write);
  cov_fault: cover property (o_fault_code != 2'h0 && o_led_status);
endmodule
bind vpc_top vpc_checker #(.HOLD_TIME(HOLD_TIME)) i_vpc_checker (.*);

// [verification/vpc_motor_model.sv]
// Drive motor with limit switches and feedback potentiometer
`timescale 1ns/100ps
module vpc_motor_model (
  input wire logic i_clock,
  input wire logic i_up,
  input wire logic i_down,
  output logic [vpc_pkg::POS_W-1:0] o_position,
  output logic o_at_low_end,
  output logic o_at_high_end
);
  import vpc_pkg::*;
  logic [POS_W-1:0] place = 10'h200;
  // Moves off the sampling edge, one step per cycle
  always @(negedge i_clock) begin
    if (i_up && !o_at_high_end) place = place + 10'h001;
    if (i_down && !o_at_low_end) place = place - 10'h001;
  end
  assign o_position = place;
  assign o_at_low_end = (place == 10'h000);
  assign o_at_high_end = (place == 10'h3FF);
endmodule

// [verification/tb_vpc_top.sv]
// Self-checking bench for the positioner commissioning logic
`timescale 1ns/100ps
module tb_vpc_top;
  import vpc_pkg::*;
  localparam int unsigned HT = 20;
  localparam int unsigned SH = 6;
  localparam int unsigned FH = 2;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic btn = 1'b0;
  logic [5:0] sw = 6'h19;
  logic mix = 1'b0;
  logic [POS_W-1:0] sp = 10'h180;
  logic [1:0] flt = 2'h0;
  logic nvv = 1'b1;
  logic [LOG_AW-1:0] laddr = 6'h00;
  logic [POS_W-1:0] pos, cal_lo, cal_hi, tgt;
  logic lo_end, hi_end, up, dn, led_up, led_dn, led_st, led_mt, nv_wr;
  logic stale, sens, dir, out020, adj, nv_seen = 1'b0;
  logic [5:0] cal_sw;
  vpc_range_t rng;
  logic [CNT_W-1:0] rcyc, eruns;
  logic [1:0] fcode;
  logic [3*POS_W-1:0] ldata;
  logic [LOG_AW-1:0] lptr;
  logic [2:0] rmap [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h1, 3'h4, 3'h5};
  int error_cnt = 0;
  int checks_done = 0;
  int rises = 0;
  ////////////////////////////////////////////////////////////////////////////
  vpc_top #(.HOLD_TIME(HT), .SLOW_HALF(SH), .FAST_HALF(FH), .LOG_PERIOD(4)) i_vpc_top (
    .i_clock(i_clock), .i_reset(i_reset), .i_adjust_button(btn), .i_switches(sw),
    .i_mixing_valve(mix), .i_setpoint(sp), .i_position(pos), .i_at_low_end(lo_end),
    .i_at_high_end(hi_end), .i_fault_code(flt), .i_nv_valid(nvv), .i_nv_low(10'h008),
    .i_nv_high(10'h3F7), .i_nv_switches(6'h19), .i_log_addr(laddr), .o_relay_up(up),
    .o_relay_down(dn), .o_led_up(led_up), .o_led_down(led_dn), .o_led_status(led_st),
    .o_led_maint(led_mt), .o_nv_write(nv_wr), .o_cal_low(cal_lo), .o_cal_high(cal_hi),
    .o_cal_switches(cal_sw), .o_cal_stale(stale), .o_input_range(rng),
    .o_sens_normal(sens), .o_direct_action(dir), .o_output_0_20(out020), .o_target(tgt),
    .o_adjusting(adj), .o_relay_cycles(rcyc), .o_end_runs(eruns), .o_fault_code(fcode),
    .o_log_data(ldata), .o_log_ptr(lptr));
  vpc_motor_model i_vpc_motor_model (.i_clock(i_clock), .i_up(up), .i_down(dn),
    .o_position(pos), .o_at_low_end(lo_end), .o_at_high_end(hi_end));
  always #50 i_clock = ~i_clock;
  always @(posedge up or posedge dn) rises++;
  always @(posedge nv_wr) nv_seen = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Cycles between two status indicator changes
  task automatic gap(output int n);
    logic v;
    n = 0;
    tick();
    v = led_st;
    for (int k = 0; k < 60 && led_st === v; k++) tick();
    v = led_st;
    for (int k = 0; k < 60 && led_st === v; k++) begin
      tick();
      n++;
    end
  endtask
  task automatic settle();
    int q;
    q = 0;
    for (int n = 0; n < 3000 && q < 5; n++) begin
      tick();
      q = (up || dn) ? 0 : q + 1;
    end
    check("settled", (pos > tgt ? pos - tgt : tgt - pos) <= 10'h004, 1'b1);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
  initial begin
    int n;
    logic lo_hit, bad;
    logic [LOG_AW-1:0] p0;
    repeat (8) tick();
    i_reset = 1'b0;
    repeat (3) tick();
    check("cal_low", cal_lo, 10'h008);
    check("cal_high", cal_hi, 10'h3F7);
    check("stale", stale, 1'b0);
    for (int k = 0; k < 8; k++) begin
      sw = {k[2:0], k[2:0]};
      mix = k[0];
      repeat (3) tick();
      check("range", rng, rmap[k]);
      check("sens", sens, k[0]);
      check("direct", dir, k[1] ^ k[0]);
      check("out_0_20", out020, !k[2]);
      check("stale", stale, 1'b1);
    end
    sw = 6'h19;
    mix = 1'b0;
    btn = 1'b1;
    repeat (10) tick();
    btn = 1'b0;
    repeat (2) tick();
    btn = 1'b1;
    repeat (HT - 5) tick();
    check("early", adj, 1'b0);
    btn = 1'b0;
    tick();
    btn = 1'b1;
    repeat (HT + 3) tick();
    check("adjusting", adj, 1'b1);
    check("seek_low", {up, dn}, 2'h1);
    btn = 1'b0;
    gap(n);
    check("slow_half", n, SH);
    lo_hit = 1'b0;
    bad = 1'b0;
    for (n = 0; n < 4000 && adj !== 1'b0; n++) begin
      tick();
      if (lo_end) lo_hit = 1'b1;
      if (up && !lo_hit) bad = 1'b1;
    end
    check("order", {lo_hit, bad}, 2'h2);
    check("cal_low", cal_lo, 10'h000);
    check("cal_high", cal_hi, 10'h3FF);
    check("stored", nv_seen, 1'b1);
    check("cal_switches", cal_sw, 6'h19);
    check("end_runs", eruns, 24'h000002);
    repeat (3) tick();
    check("status", led_st, 1'b1);
    settle();
    check("target", tgt, 10'h180);
    check("relay_cycles", rcyc, rises);
    mix = 1'b1;
    settle();
    check("target", tgt, 10'h27F);
    p0 = lptr;
    repeat (8) tick();
    check("log_ptr", lptr, 6'(p0 + 6'h02));
    laddr = lptr - 6'h01;
    repeat (2) tick();
    check("log_data", ldata, {pos, sp, pos});
    flt = 2'h2;
    repeat (4) tick();
    check("fault_code", fcode, 2'h2);
    check("relays", {up, dn}, 2'h0);
    gap(n);
    check("fast_half", n, FH);
    flt = 2'h0;
    nvv = 1'b0;
    i_reset = 1'b1;
    repeat (2) tick();
    i_reset = 1'b0;
    repeat (3) tick();
    check("cal_low", cal_lo, DEFAULT_LOW);
    check("cal_high", cal_hi, DEFAULT_HIGH);
    check("cal_switches", cal_sw, 6'h19);
    check("stale", stale, 1'b0);
    check("relay_cycles", rcyc, 24'h000000);
    check("maint", led_mt, 1'b0);
    final_report();
  end
endmodule
